// ---- siwsc_defines.svh ----
`ifndef SIWSC_DEFINES_SVH
`define SIWSC_DEFINES_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define SIWSC_A_COMMIT    16'h000F
`define SIWSC_A_PINCFG    16'h0100
`define SIWSC_A_WD_LO     16'h010D
`define SIWSC_A_WD_HI     16'h010E
`define SIWSC_A_MASK      16'h010F
`define SIWSC_A_STAB_LO   16'h0207
`define SIWSC_A_STAB_HI   16'h0208
`define SIWSC_A_CALCTL    16'h0A00
`define SIWSC_A_CLR       16'h0A05
`define SIWSC_A_CLRGRP    16'h0A06
`define SIWSC_A_LOCKSUM   16'h0D00
`define SIWSC_A_STATUS    16'h0D01
`define SIWSC_A_MONITOR   16'h0D08
`define SIWSC_STATUS_PAGE 8'h0D
// ----------------------------------------
// field positions
// ----------------------------------------
`define SIWSC_COMMIT_BIT  0
`define SIWSC_CAL_ALL_BIT 1
`define SIWSC_CAL_SYS_BIT 2
`define SIWSC_SYNC_ALL_BIT 3
`define SIWSC_CLR_ALL_BIT 0
`define SIWSC_CLR_WD_BIT  7
`define SIWSC_STABLE_BIT  1
`define SIWSC_WD_EVT_BIT  7
// ----------------------------------------
// reset values
// ----------------------------------------
`define SIWSC_MASK_RST    8'h00
`define SIWSC_PINCFG_RST  8'h00
`define SIWSC_WD_RST      16'h0000
`define SIWSC_STAB_RST    16'h0032
`define SIWSC_CAL_RST     8'h00
`define SIWSC_PIN_PULL    7'b010_0000
`define SIWSC_I2C_PREFIX  4'b1101
// ----------------------------------------
// timing
// ----------------------------------------
`define SIWSC_CLK_NS      5
`define SIWSC_MS_NS       1000000
`define SIWSC_MS_CYC      (`SIWSC_MS_NS / `SIWSC_CLK_NS)
`define SIWSC_POR_MS      25
`define SIWSC_STRAP_MS    25
`define SIWSC_HOST_WAIT_MS 25
`define SIWSC_WD_PULSE_NS 40
`define SIWSC_WD_PULSE_CYC ((`SIWSC_WD_PULSE_NS + `SIWSC_CLK_NS - 1) / `SIWSC_CLK_NS)
`define SIWSC_A_HOST_CMD  4'h0
`define SIWSC_A_HOST_STAT 4'h4
`endif

// ---- siwsc_device.sv ----
`timescale 1ns/1ps
`include "siwsc_defines.svh"
module siwsc_device
  import siwsc_pkg::*;
#(
  parameter int MS_CYC = `SIWSC_MS_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  siwsc_link_if.device     link,
  input  wire logic        supply_ok,
  input  wire logic        reset_pin_n,
  input  wire logic        system_clock_multiplier_locked,
  input  wire logic [3:0]  digital_loop_locked,
  input  wire logic [3:0]  analog_loop_locked,
  input  wire logic [39:0] irq_event,
  output logic             device_in_reset,
  output logic             straps_latched,
  output siwsc_serial_t    serial_mode,
  output logic [6:0]       i2c_addr,
  output logic             commit_pulse,
  output logic             system_clock_multiplier_cal,
  output logic             system_clock_multiplier_stable,
  output logic [3:0]       analog_loop_cal,
  output logic [3:0]       analog_loop_sync,
  output logic             digital_loop_enable
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [1:0] drive(input logic [1:0] mode, input logic act);
    // returns {oe, level}
    case (mode)
      SIWSC_DRV_PP_HIGH: drive = {1'b1, act};
      SIWSC_DRV_PP_LOW:  drive = {1'b1, ~act};
      SIWSC_DRV_OD_PMOS: drive = {act, 1'b1};
      default:           drive = {act, 1'b0};
    endcase
  endfunction : drive

  function automatic logic hit(input logic [15:0] a, input logic [15:0] base, input int n);
    hit = (a >= base) && (a < base + 16'(n));
  endfunction : hit

  // ----------------------------------------
  // ms tick, power-on reset, straps
  // ----------------------------------------
  logic [31:0] div_r;
  logic        ms_tick;
  logic [5:0]  por_cnt_r;
  logic [5:0]  strap_cnt_r;
  logic        pin_rst_d_r;
  logic [6:0]  strap_r;
  logic        por_active;
  logic        in_reset;

  assign ms_tick    = (div_r == 32'(MS_CYC - 1));
  assign por_active = por_cnt_r < 6'(`SIWSC_POR_MS);
  assign in_reset   = por_active | ~reset_pin_n;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r         <= 32'h0000_0000;
      por_cnt_r     <= 6'h00;
      strap_cnt_r   <= 6'h00;
      pin_rst_d_r   <= 1'b1;
      strap_r       <= 7'h00;
      straps_latched <= 1'b0;
    end else begin
      div_r       <= ms_tick ? 32'h0000_0000 : div_r + 32'h0000_0001;
      pin_rst_d_r <= in_reset;
      if (!supply_ok) begin
        por_cnt_r      <= 6'h00;
        strap_cnt_r    <= 6'h00;
        straps_latched <= 1'b0;
      end else if (por_active) begin
        if (ms_tick) por_cnt_r <= por_cnt_r + 6'h01;
      end else if (strap_cnt_r < 6'(`SIWSC_STRAP_MS)) begin
        if (ms_tick) strap_cnt_r <= strap_cnt_r + 6'h01;
        if (ms_tick && strap_cnt_r == 6'(`SIWSC_STRAP_MS - 1)) begin
          strap_r        <= link.pin_level;
          straps_latched <= 1'b1;
        end
      end else if (pin_rst_d_r && !in_reset) begin
        strap_r <= link.pin_level;
      end
    end
  end

  // pin index 4..6 are pins 5..7; there is no pin 4
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_mode     <= SIWSC_SERIAL_NONE;
      i2c_addr        <= 7'h00;
      device_in_reset <= 1'b1;
    end else begin
      device_in_reset <= in_reset;
      serial_mode <= strap_r[4] ? SIWSC_SERIAL_I2C :
                     (strap_r[5] ? SIWSC_SERIAL_SPI : SIWSC_SERIAL_NONE);
      i2c_addr    <= {`SIWSC_I2C_PREFIX, strap_r[0], strap_r[6], strap_r[5]};
    end
  end

  // ----------------------------------------
  // register file: buffered and active copies
  // ----------------------------------------
  logic [7:0]  pincfg_buf_r [7];
  logic [7:0]  pincfg_r     [7];
  logic [7:0]  mask_buf_r   [5];
  logic [7:0]  mask_r       [5];
  logic [7:0]  mon_r        [5];
  logic [15:0] wd_buf_r;
  logic [15:0] wd_r;
  logic [15:0] stab_buf_r;
  logic [15:0] stab_r;
  logic [7:0]  cal_buf_r;
  logic [7:0]  cal_r;
  logic        commit_r;

  wire [15:0] a      = link.reg_addr;
  wire [7:0]  d      = link.reg_wdata;
  wire        wr     = link.reg_wr & ~in_reset;
  wire        rd     = link.reg_rd;
  wire        wr_commit = wr && a == `SIWSC_A_COMMIT && d[`SIWSC_COMMIT_BIT];
  wire        wr_clr    = wr && a == `SIWSC_A_CLR;
  wire        clr_all   = wr_clr && d[`SIWSC_CLR_ALL_BIT];
  wire        wd_clear  = wr_clr && d[`SIWSC_CLR_WD_BIT];
  wire        cal_start = commit_r && (cal_buf_r[`SIWSC_CAL_ALL_BIT] ||
                          (cal_buf_r[`SIWSC_CAL_SYS_BIT] && !cal_r[`SIWSC_CAL_SYS_BIT]));
  wire        wd_expire;

  always_ff @(posedge aclk) begin
    if (!aresetn || in_reset) begin
      for (int i = 0; i < 7; i++) begin
        pincfg_buf_r[i] <= `SIWSC_PINCFG_RST;
        pincfg_r[i]     <= `SIWSC_PINCFG_RST;
      end
      for (int g = 0; g < 5; g++) begin
        mask_buf_r[g] <= `SIWSC_MASK_RST;
        mask_r[g]     <= `SIWSC_MASK_RST;
      end
      wd_buf_r   <= `SIWSC_WD_RST;
      wd_r       <= `SIWSC_WD_RST;
      stab_buf_r <= `SIWSC_STAB_RST;
      stab_r     <= `SIWSC_STAB_RST;
      cal_buf_r  <= `SIWSC_CAL_RST;
      cal_r      <= `SIWSC_CAL_RST;
      commit_r   <= 1'b0;
    end else begin
      commit_r <= wr_commit;
      if (wr && hit(a, `SIWSC_A_PINCFG, 7)) pincfg_buf_r[a[2:0]] <= d;
      if (wr && hit(a, `SIWSC_A_MASK, 5)) mask_buf_r[3'(a - `SIWSC_A_MASK)] <= d;
      if (wr && a == `SIWSC_A_WD_LO) wd_buf_r[7:0] <= d;
      if (wr && a == `SIWSC_A_WD_HI) wd_buf_r[15:8] <= d;
      if (wr && a == `SIWSC_A_STAB_LO) stab_buf_r[7:0] <= d;
      if (wr && a == `SIWSC_A_STAB_HI) stab_buf_r[15:8] <= d;
      if (wr && a == `SIWSC_A_CALCTL) cal_buf_r <= d;
      if (commit_r) begin
        pincfg_r <= pincfg_buf_r;
        mask_r   <= mask_buf_r;
        wd_r     <= wd_buf_r;
        stab_r   <= stab_buf_r;
        cal_r    <= cal_buf_r;
      end
    end
  end

  // ----------------------------------------
  // interrupt monitors, set beats clear
  // ----------------------------------------
  wire [39:0] evt = irq_event | {32'h0000_0000, wd_expire, 7'h00};
  always_ff @(posedge aclk) begin
    if (!aresetn || in_reset) begin
      for (int g = 0; g < 5; g++) mon_r[g] <= 8'h00;
    end else begin
      for (int g = 0; g < 5; g++) begin
        mon_r[g] <= (mon_r[g] & ~((wr && a == `SIWSC_A_CLRGRP + 16'(g)) ? d : 8'h00)
                     & ~{8{clr_all}})
                    | (evt[g*8 +: 8] & mask_r[g]);
      end
    end
  end

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  logic [15:0] wd_cnt_r;
  logic [3:0]  wd_pulse_r;
  assign wd_expire = (wd_r != 16'h0000) && ms_tick && (wd_cnt_r >= wd_r - 16'h0001);

  always_ff @(posedge aclk) begin
    if (!aresetn || in_reset) begin
      wd_cnt_r   <= 16'h0000;
      wd_pulse_r <= 4'h0;
    end else begin
      if (wd_clear || wd_r == 16'h0000 || wd_expire) wd_cnt_r <= 16'h0000;
      else if (ms_tick) wd_cnt_r <= wd_cnt_r + 16'h0001;
      if (wd_expire) wd_pulse_r <= 4'(`SIWSC_WD_PULSE_CYC);
      else if (wd_pulse_r != 4'h0) wd_pulse_r <= wd_pulse_r - 4'h1;
    end
  end

  // ----------------------------------------
  // system clock calibration and stability
  // ----------------------------------------
  siwsc_sc_state_t sc_r;
  logic [15:0]     stab_cnt_r;
  logic [3:0]      analog_loop_pend_r;

  always_ff @(posedge aclk) begin
    if (!aresetn || in_reset) begin
      sc_r        <= SIWSC_SC_IDLE;
      stab_cnt_r  <= 16'h0000;
      analog_loop_pend_r <= 4'h0;
    end else begin
      if (cal_start) sc_r <= SIWSC_SC_CAL;
      else begin
        case (sc_r)
          SIWSC_SC_IDLE:   sc_r <= SIWSC_SC_IDLE;
          SIWSC_SC_CAL:    sc_r <= SIWSC_SC_WAIT;
          SIWSC_SC_WAIT:   if (system_clock_multiplier_locked && ms_tick && stab_cnt_r >= stab_r) sc_r <= SIWSC_SC_STABLE;
          SIWSC_SC_STABLE: if (!system_clock_multiplier_locked) sc_r <= SIWSC_SC_WAIT;
          default:         sc_r <= SIWSC_SC_IDLE;
        endcase
      end
      if (sc_r != SIWSC_SC_WAIT || !system_clock_multiplier_locked) stab_cnt_r <= 16'h0000;
      else if (ms_tick) stab_cnt_r <= stab_cnt_r + 16'h0001;
      // analog loops calibrate only once the clock is stable
      if (commit_r && cal_buf_r[`SIWSC_CAL_ALL_BIT]) analog_loop_pend_r <= 4'hF;
      else if (sc_r == SIWSC_SC_STABLE) analog_loop_pend_r <= 4'h0;
    end
  end

  // ----------------------------------------
  // outputs and pin drivers
  // ----------------------------------------
  wire       irq_any = |{mon_r[0], mon_r[1], mon_r[2], mon_r[3], mon_r[4]};
  logic      pin_act [7];
  logic [1:0] pin_drv [7];
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      case (pincfg_r[i][5:2])
        4'h1:    pin_act[i] = irq_any;
        4'h2:    pin_act[i] = |mon_r[0];
        4'h3:    pin_act[i] = |mon_r[1];
        4'h4:    pin_act[i] = |mon_r[2];
        4'h5:    pin_act[i] = |mon_r[3];
        4'h6:    pin_act[i] = |mon_r[4];
        4'h7:    pin_act[i] = wd_pulse_r != 4'h0;
        4'h8:    pin_act[i] = sc_r == SIWSC_SC_STABLE;
        default: pin_act[i] = 1'b0;
      endcase
      pin_drv[i] = drive(pincfg_r[i][1:0], pin_act[i]);
    end
  end

  wire [7:0] stat_rd = (a == `SIWSC_A_STATUS)  ? {6'h00, sc_r == SIWSC_SC_STABLE, system_clock_multiplier_locked} :
                       (a == `SIWSC_A_LOCKSUM) ? {digital_loop_locked, analog_loop_locked} :
                       hit(a, `SIWSC_A_MONITOR, 5) ? mon_r[3'(a - `SIWSC_A_MONITOR)] : 8'h00;
  wire [7:0] cfg_rd  = hit(a, `SIWSC_A_PINCFG, 7) ? pincfg_buf_r[a[2:0]] :
                       hit(a, `SIWSC_A_MASK, 5)   ? mask_buf_r[3'(a - `SIWSC_A_MASK)] :
                       (a == `SIWSC_A_WD_LO)   ? wd_buf_r[7:0]   :
                       (a == `SIWSC_A_WD_HI)   ? wd_buf_r[15:8]  :
                       (a == `SIWSC_A_STAB_LO) ? stab_buf_r[7:0] :
                       (a == `SIWSC_A_STAB_HI) ? stab_buf_r[15:8] :
                       (a == `SIWSC_A_CALCTL)  ? cal_buf_r : 8'h00;
  // status page lives on the system clock domain: no lock, no readback
  wire [7:0] rd_val  = (a[15:8] == `SIWSC_STATUS_PAGE) ? (system_clock_multiplier_locked ? stat_rd : 8'h00) : cfg_rd;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.reg_rdata  <= 8'h00;
      link.reg_rvalid <= 1'b0;
      link.pin_dev_o  <= 7'h00;
      link.pin_dev_oe <= 7'h00;
      commit_pulse    <= 1'b0;
      system_clock_multiplier_cal      <= 1'b0;
      system_clock_multiplier_stable   <= 1'b0;
      analog_loop_cal        <= 4'h0;
      analog_loop_sync       <= 4'h0;
      digital_loop_enable     <= 1'b0;
    end else begin
      link.reg_rvalid <= rd;
      link.reg_rdata  <= rd ? rd_val : 8'h00;
      for (int i = 0; i < 7; i++) begin
        link.pin_dev_oe[i] <= pin_drv[i][1] & straps_latched & ~in_reset;
        link.pin_dev_o[i]  <= pin_drv[i][0];
      end
      commit_pulse  <= commit_r;
      system_clock_multiplier_cal    <= sc_r == SIWSC_SC_CAL;
      system_clock_multiplier_stable <= sc_r == SIWSC_SC_STABLE;
      analog_loop_cal      <= (sc_r == SIWSC_SC_STABLE) ? analog_loop_pend_r : 4'h0;
      analog_loop_sync     <= {4{commit_r & cal_buf_r[`SIWSC_SYNC_ALL_BIT]}};
      digital_loop_enable   <= system_clock_multiplier_locked & ~in_reset;
    end
  end
endmodule : siwsc_device

// ---- siwsc_host.sv ----
`timescale 1ns/1ps
`include "siwsc_defines.svh"
module siwsc_host
  import siwsc_pkg::*;
#(
  parameter int MS_CYC = `SIWSC_MS_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  siwsc_link_if.host       link,
  input  wire logic [6:0]  strap_value,
  input  wire logic        strap_drive,
  output logic [6:0]       mf_level,
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);
  // ----------------------------------------
  // power-up wait
  // ----------------------------------------
  logic [31:0] div_r;
  logic [5:0]  wait_ms_r;
  wire         ms_tick   = (div_r == 32'(MS_CYC - 1));
  wire         wait_done = wait_ms_r >= 6'(`SIWSC_HOST_WAIT_MS);

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  logic        aw_got_r;
  logic        w_got_r;
  logic [3:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic        cmd_pend_r;
  logic        cmd_write_r;
  logic [15:0] cmd_addr_r;
  logic [7:0]  cmd_data_r;
  logic [7:0]  last_rd_r;
  logic        keep_cal_r;
  siwsc_host_state_t st_r;

  wire wr_go   = aw_got_r & w_got_r & ~bvalid;
  wire wr_cmd  = wr_go & (aw_addr_r == `SIWSC_A_HOST_CMD) & ~cmd_pend_r & (st_r == SIWSC_H_IDLE);
  wire map_ok  = (aw_addr_r == `SIWSC_A_HOST_CMD) | (aw_addr_r == `SIWSC_A_HOST_STAT);
  wire busy    = cmd_pend_r | (st_r != SIWSC_H_IDLE);
  // once set, the system_clock_multiplier calibrate bit rides along in every later write to CALCTL
  wire [7:0] out_data = (cmd_write_r && cmd_addr_r == `SIWSC_A_CALCTL && keep_cal_r) ?
                        (cmd_data_r | 8'h04) : cmd_data_r;
  wire [31:0] stat_word = {15'h0000, keep_cal_r, last_rd_r, 6'h00, wait_done, busy};
  wire [31:0] rd_word   = (araddr == `SIWSC_A_HOST_STAT) ? stat_word :
                          (araddr == `SIWSC_A_HOST_CMD)  ? {7'h00, cmd_write_r, cmd_data_r, cmd_addr_r} :
                          32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= 2'b00;
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rresp   <= 2'b00;
      rdata   <= 32'h0000_0000;
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      aw_addr_r <= 4'h0;
      w_data_r  <= 32'h0000_0000;
    end else begin
      if (awvalid && awready) begin
        awready   <= 1'b0;
        aw_got_r  <= 1'b1;
        aw_addr_r <= awaddr;
      end
      if (wvalid && wready) begin
        wready   <= 1'b0;
        w_got_r  <= 1'b1;
        w_data_r <= {wstrb[3] ? wdata[31:24] : 8'h00, wstrb[2] ? wdata[23:16] : 8'h00,
                     wstrb[1] ? wdata[15:8] : 8'h00, wstrb[0] ? wdata[7:0] : 8'h00};
      end
      if (wr_go) begin
        bvalid   <= 1'b1;
        bresp    <= map_ok ? 2'b00 : 2'b11;
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rd_word;
        rresp   <= ((araddr == `SIWSC_A_HOST_CMD) || (araddr == `SIWSC_A_HOST_STAT)) ? 2'b00 : 2'b11;
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // link sequencer
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r       <= 32'h0000_0000;
      wait_ms_r   <= 6'h00;
      cmd_pend_r  <= 1'b0;
      cmd_write_r <= 1'b0;
      cmd_addr_r  <= 16'h0000;
      cmd_data_r  <= 8'h00;
      last_rd_r   <= 8'h00;
      keep_cal_r  <= 1'b0;
      st_r        <= SIWSC_H_IDLE;
      link.reg_wr    <= 1'b0;
      link.reg_rd    <= 1'b0;
      link.reg_addr  <= 16'h0000;
      link.reg_wdata <= 8'h00;
      link.pin_host_o  <= 7'h00;
      link.pin_host_oe <= 7'h00;
      mf_level    <= 7'h00;
    end else begin
      div_r <= ms_tick ? 32'h0000_0000 : div_r + 32'h0000_0001;
      if (ms_tick && !wait_done) wait_ms_r <= wait_ms_r + 6'h01;
      link.pin_host_o  <= strap_value;
      link.pin_host_oe <= {7{strap_drive}};
      mf_level    <= link.pin_level;
      link.reg_wr <= 1'b0;
      link.reg_rd <= 1'b0;
      if (wr_cmd) begin
        cmd_pend_r  <= 1'b1;
        cmd_addr_r  <= w_data_r[15:0];
        cmd_data_r  <= w_data_r[23:16];
        cmd_write_r <= w_data_r[24];
      end
      case (st_r)
        SIWSC_H_IDLE: if (cmd_pend_r && wait_done) st_r <= SIWSC_H_ISSUE;
        SIWSC_H_ISSUE: begin
          link.reg_wr    <= cmd_write_r;
          link.reg_rd    <= ~cmd_write_r;
          link.reg_addr  <= cmd_addr_r;
          link.reg_wdata <= out_data;
          if (cmd_write_r && cmd_addr_r == `SIWSC_A_CALCTL && out_data[`SIWSC_CAL_SYS_BIT])
            keep_cal_r <= 1'b1;
          cmd_pend_r <= 1'b0;
          st_r <= cmd_write_r ? SIWSC_H_IDLE : SIWSC_H_WAIT;
        end
        SIWSC_H_WAIT: if (link.reg_rvalid) begin
          last_rd_r <= link.reg_rdata;
          st_r      <= SIWSC_H_IDLE;
        end
        default: st_r <= SIWSC_H_IDLE;
      endcase
    end
  end
endmodule : siwsc_host

// ---- siwsc_link_if.sv ----
`timescale 1ns/1ps
`include "siwsc_defines.svh"
interface siwsc_link_if;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic [6:0]  pin_dev_o;
  logic [6:0]  pin_dev_oe;
  logic [6:0]  pin_host_o;
  logic [6:0]  pin_host_oe;
  wire  [6:0]  pin_level;

  // board pulls win only when nobody drives
  assign pin_level = (pin_dev_oe & pin_dev_o) | (~pin_dev_oe & pin_host_oe & pin_host_o)
                   | (~pin_dev_oe & ~pin_host_oe & `SIWSC_PIN_PULL);

  modport device (input reg_wr, reg_rd, reg_addr, reg_wdata, pin_level,
                  output reg_rdata, reg_rvalid, pin_dev_o, pin_dev_oe);
  modport host   (output reg_wr, reg_rd, reg_addr, reg_wdata, pin_host_o, pin_host_oe,
                  input reg_rdata, reg_rvalid, pin_level);
endinterface : siwsc_link_if

// ---- siwsc_link_properties.sv ----
`timescale 1ns/1ps
module siwsc_link_properties (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_rdata,
  input wire logic [6:0]  pin_dev_oe,
  input wire logic        system_clock_multiplier_locked,
  input wire logic        system_clock_multiplier_stable,
  input wire logic        device_in_reset,
  input wire logic        commit_pulse,
  input wire logic        system_clock_multiplier_cal,
  input wire logic [3:0]  analog_loop_cal
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_hiz; device_in_reset && $past(device_in_reset) |-> pin_dev_oe == 7'h00; endproperty
  a_hiz: assert property (p_hiz) else $error("pin driven in reset");
  property p_rel; $rose(aresetn) |-> (pin_dev_oe == 7'h00) [*8]; endproperty
  a_rel: assert property (p_rel) else $error("pin driven at release");
  property p_unlk; reg_rd && reg_addr[15:8] == 8'h0D && !system_clock_multiplier_locked |=> reg_rdata == 8'h00; endproperty
  a_unlk: assert property (p_unlk) else $error("status read unlocked");
  property p_stb; reg_rd && reg_addr == 16'h0D01 && system_clock_multiplier_locked |=> reg_rdata[1] == $past(system_clock_multiplier_stable); endproperty
  a_stb: assert property (p_stb) else $error("stable bit wrong");
  property p_wait; $rose(system_clock_multiplier_locked) |-> (!system_clock_multiplier_stable) [*8]; endproperty
  a_wait: assert property (p_wait) else $error("stable too early");
  property p_cal; system_clock_multiplier_cal |-> $past(commit_pulse); endproperty
  a_cal: assert property (p_cal) else $error("cal without commit");
  property p_once; commit_pulse |=> !commit_pulse; endproperty
  a_once: assert property (p_once) else $error("commit repeated");
  property p_analog_loop; |analog_loop_cal |-> system_clock_multiplier_stable; endproperty
  a_analog_loop: assert property (p_analog_loop) else $error("loop cal unstable");
endmodule : siwsc_link_properties

// ---- siwsc_pkg.sv ----
package siwsc_pkg;
  typedef enum logic [1:0] {
    SIWSC_SC_IDLE   = 2'b00,
    SIWSC_SC_CAL    = 2'b01,
    SIWSC_SC_WAIT   = 2'b11,
    SIWSC_SC_STABLE = 2'b10
  } siwsc_sc_state_t;

  typedef enum logic [1:0] {
    SIWSC_H_IDLE  = 2'b00,
    SIWSC_H_ISSUE = 2'b01,
    SIWSC_H_WAIT  = 2'b11
  } siwsc_host_state_t;

  typedef enum logic [1:0] {
    SIWSC_SERIAL_NONE = 2'b00,
    SIWSC_SERIAL_SPI  = 2'b01,
    SIWSC_SERIAL_I2C  = 2'b10
  } siwsc_serial_t;

  typedef enum logic [1:0] {
    SIWSC_DRV_PP_HIGH = 2'b00,
    SIWSC_DRV_PP_LOW  = 2'b01,
    SIWSC_DRV_OD_PMOS = 2'b10,
    SIWSC_DRV_OD_NMOS = 2'b11
  } siwsc_drive_t;
endpackage : siwsc_pkg

// ---- tb_siwsc.sv ----
`timescale 1ns/1ps
`define CHK(n, x, g) begin n_tests++; if ((g) !== (x)) begin bad_count++; $display("Error %s exp %h got %h", n, x, g); end end
module tb_siwsc import siwsc_pkg::*; ();
  localparam int MS = 20;
  logic aclk = 0, aresetn = 0, supply_ok = 1, reset_pin_n = 1, system_clock_multiplier_locked = 0, strap_drive = 1;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
  logic device_in_reset, straps_latched, commit_pulse, system_clock_multiplier_cal, system_clock_multiplier_stable, digital_loop_enable;
  logic [3:0] digital_loop_locked = 0, analog_loop_locked = 0, awaddr = 0, araddr = 0, wstrb = 4'hF, analog_loop_cal, analog_loop_sync;
  logic [39:0] irq_event = 0;
  logic [6:0] strap_value = 0, mf_level, i2c_addr;
  logic [31:0] wdata = 0, rdata, rd, seed = 32'h9a05;
  logic [7:0] rb, m, e;
  logic [1:0] bresp, rresp, rsp;
  siwsc_serial_t serial_mode;
  int bad_count = 0, n_tests = 0, cyc = 0, ncal = 0, ncom = 0, nsync = 0, n;
  siwsc_link_if link ();
  siwsc_device #(.MS_CYC(MS)) i_siwsc_device (.*);
  siwsc_host #(.MS_CYC(MS)) i_siwsc_host (.*);
  siwsc_link_properties i_siwsc_link_properties (.*, .reg_rd(link.reg_rd), .reg_addr(link.reg_addr),
    .reg_rdata(link.reg_rdata), .pin_dev_oe(link.pin_dev_oe));
  always #2.5 aclk = ~aclk;
  always @(posedge aclk) begin
    ncal <= ncal + system_clock_multiplier_cal;
    ncom <= ncom + commit_pulse;
    nsync <= nsync + (analog_loop_sync == 4'hF);
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic conclude();
    $display("tests %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  // every wait goes through here, so a hang ends the run
  task automatic tick();
    @(posedge aclk);
    cyc++;
    if (cyc > 30000) begin
      bad_count++;
      conclude();
    end
  endtask : tick
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    tick();
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      tick();
      if (awready && awvalid) awvalid <= 0;
      if (wready && wvalid) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
    rsp = bresp;
  endtask : axw
  task automatic axr(input logic [3:0] a);
    tick();
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      tick();
      if (arready && arvalid) arvalid <= 0;
    end while (!rvalid);
    rready <= 0;
    rd = rdata;
    rsp = rresp;
  endtask : axr
  task automatic dev(input logic [15:0] a, input logic [7:0] d, input logic w);
    axw(4'h0, {7'h00, w, d, a});
    repeat (4) tick();
    rd = 1;
    while (rd[0]) axr(4'h4);
    rb = rd[15:8];
  endtask : dev
  task automatic rst(input logic [6:0] s);
    aresetn <= 0;
    strap_value <= s;
    repeat (2) tick();
    aresetn <= 1;
    n = 0;
    do begin
      tick();
      n++;
    end while (!straps_latched);
    tick();
    `CHK("latch_time", 1'b1, n > 50 * MS - 4 && n < 50 * MS + 8)
    `CHK("mode", (s[4] ? SIWSC_SERIAL_I2C : s[5] ? SIWSC_SERIAL_SPI : SIWSC_SERIAL_NONE), serial_mode)
    if (s[4]) `CHK("addr", {4'hD, s[0], s[6], s[5]}, i2c_addr)
    $display("straps %h done", s);
  endtask : rst
  initial begin
    for (int k = 0; k < 3; k++) rst(k == 0 ? 7'h00 : k == 1 ? 7'h20 : 7'(rnd()) | 7'h10);
    dev(16'h0D01, 8'h00, 0);
    `CHK("unlocked", 8'h00, rb)
    `CHK("pins", 7'h00, mf_level)
    dev(16'h0A00, 8'h04, 1);
    `CHK("armed", 0, ncal)
    dev(16'h000F, 8'h01, 1);
    `CHK("cal", 1, ncal)
    `CHK("commit", 1, ncom)
    system_clock_multiplier_locked <= 1;
    n = 0;
    while (!system_clock_multiplier_stable) begin
      tick();
      n++;
    end
    `CHK("stable_time", 1'b1, n > 50 * MS && n < 51 * MS + 8)
    `CHK("digital_loop_en", 1'b1, digital_loop_enable)
    dev(16'h0D01, 8'h00, 0);
    `CHK("status", 8'h03, rb)
    `CHK("rresp", 2'h0, rsp)
    {digital_loop_locked, analog_loop_locked} <= 8'(rnd());
    m = 8'(rnd());
    e = 8'(rnd()) & 8'h7F;
    dev(16'h010F, m, 1);
    dev(16'h000F, 8'h01, 1);
    irq_event[7:0] <= e;
    tick();
    irq_event[7:0] <= 8'h00;
    dev(16'h0D08, 8'h00, 0);
    `CHK("monitor", m & e, rb)
    dev(16'h0D00, 8'h00, 0);
    `CHK("lock_sum", {digital_loop_locked, analog_loop_locked}, rb)
    dev(16'h0A05, 8'h01, 1);
    dev(16'h0D08, 8'h00, 0);
    `CHK("cleared", 8'h00, rb)
    axw(4'h8, 0);
    `CHK("bresp", 2'h3, rsp)
    dev(16'h0A00, 8'h0A, 1);
    dev(16'h0A00, 8'h00, 0);
    `CHK("keep_cal", 8'h0E, rb)
    dev(16'h000F, 8'h01, 1);
    `CHK("cal_all", 2, ncal)
    `CHK("sync_all", 1, nsync)
    n = 0;
    while (analog_loop_cal != 4'hF) begin
      tick();
      n++;
    end
    `CHK("analog_loop_wait", 1'b1, n > 49 * MS && system_clock_multiplier_stable)
    dev(16'h0100, 8'h1C, 1);
    dev(16'h010D, 8'h01, 1);
    dev(16'h000F, 8'h01, 1);
    n = 0;
    while (!mf_level[0]) tick();
    while (mf_level[0]) begin
      tick();
      n++;
    end
    `CHK("wd_pulse", 40 / 5, n)
    strap_value <= 7'h20;
    reset_pin_n <= 0;
    repeat (3) tick();
    `CHK("hiz", 7'h20, mf_level)
    `CHK("in_reset", 1'b1, device_in_reset)
    reset_pin_n <= 1;
    repeat (3) tick();
    `CHK("recapture", SIWSC_SERIAL_SPI, serial_mode)
    $display("irq and bus done");
    conclude();
  end
endmodule : tb_siwsc
